// ==== hdl/wriu_pkg.sv ====
/*
  Shared constants and types of the working register block.
  Assumes one core clock and the core reset; no software access.
*/
package wriu_pkg;

  // ----------------------------------------------------------------
  // Register file shape
  // ----------------------------------------------------------------
  localparam int WRIU_NUM_REGS  = 16;        // Working registers
  localparam int WRIU_REG_WIDTH = 16;        // Bits per register

  // ----------------------------------------------------------------
  // Fixed register roles
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_DEFAULT = 4'h0; // Default working register
  localparam logic [3:0] IDX_PROD_LO = 4'h2; // Legacy product low word
  localparam logic [3:0] IDX_PROD_HI = 4'h3; // Legacy product high word
  localparam logic [3:0] IDX_MAC_OP  = 4'h4; // First multiplicand register
  localparam logic [3:0] IDX_PTR_X   = 4'h8; // First X prefetch pointer
  localparam logic [3:0] IDX_PTR_Y   = 4'ha; // First Y prefetch pointer
  localparam logic [3:0] IDX_OFFSET  = 4'hc; // Prefetch offset index
  localparam logic [3:0] IDX_WB      = 4'hd; // Accumulator write-back
  localparam logic [3:0] IDX_FP      = 4'he; // Frame pointer
  localparam logic [3:0] IDX_SP      = 4'hf; // Stack pointer

  // ----------------------------------------------------------------
  // Encodings, steps and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  SIGN_SIGNED   = 2'h0;    // Both signed
  localparam logic [1:0]  SIGN_UNSIGNED = 2'h1;    // Both unsigned
  localparam logic [1:0]  SIGN_MIXED    = 2'h2;    // Sign by register
  localparam logic [15:0] STACK_STEP    = 16'h0002; // One word on stack
  localparam logic [15:0] CALL_STEP     = 16'h0004; // Return address
  localparam logic [15:0] WORD_RESET    = 16'h0000; // Register reset value

  // Operations presented by the core decoder
  typedef enum logic [4:0] {
    op_nop, op_wr_word, op_rd_word, op_ld_dflt, op_st_dflt, op_lmul,
    op_mul_pair, op_acc_read,
    op_clr, op_dist, op_dist_acc, op_mac, op_pstore, op_mpy, op_mpy_neg,
    op_msub,
    op_push, op_pop, op_call, op_relative_call_op, op_trap, op_ret, op_ret_int,
    op_ret_lit, op_link, op_unlink
  } wriu_op_t;

  // Whole state of the block
  typedef struct packed {
    logic [WRIU_NUM_REGS-1:0][WRIU_REG_WIDTH-1:0] w; // Register array
    logic [15:0] rd;     // Read data
    logic [31:0] prod;   // Multiplier result
    logic [15:0] maddr;  // Stack or frame memory address
    logic [15:0] xaddr;  // X prefetch address
    logic [15:0] yaddr;  // Y prefetch address
    logic        done;   // Operation finished
  } wriu_state_t;

endpackage

// ==== hdl/wriu_regfile.sv ====
/*
  Working register array of the core with its implied register roles:
  multiply-accumulate operands, prefetch pointers, offset, write-back,
  frame and stack pointers, default register and legacy product pair.
  Assumes a decoder on the same clock presents one operation per
  enabled cycle and supplies memory data on file_data_in.
*/
`timescale 1ns/1ps

module wriu_regfile
  import wriu_pkg::*;
(
  input  wire logic        clk_in,          // Core clock
  input  wire logic        rst_in,          // Async reset, high
  input  wire logic        ce_in,           // Clock enable
  input  wire logic        op_valid_in,     // Operation present
  input  wire wriu_op_t    op_in,           // Operation code
  input  wire logic        byte_in,         // Byte mode
  input  wire logic [3:0]  reg_a_in,        // Source register
  input  wire logic [3:0]  reg_b_in,        // Second source
  input  wire logic [3:0]  dst_in,          // Destination register
  input  wire logic [15:0] file_data_in,    // Memory data
  input  wire logic [15:0] frame_lit_in,    // Frame size literal
  input  wire logic [1:0]  pair_unsigned_in, // Unsigned a, b
  input  wire logic        acc_dest_in,     // Product to accumulator
  input  wire logic [1:0]  multiply_sign_select_in, // MAC signs
  input  wire logic [1:0]  x_op_sel_in,     // Operand W4..W7
  input  wire logic [1:0]  y_op_sel_in,     // Operand W4..W7
  input  wire logic        px_en_in,        // X prefetch
  input  wire logic        px_sel_in,       // W8 or W9
  input  wire logic        px_off_in,       // Add W12
  input  wire logic [15:0] px_step_in,      // X post-modify
  input  wire logic        py_en_in,        // Y prefetch
  input  wire logic        py_sel_in,       // W10 or W11
  input  wire logic        py_off_in,       // Add W12
  input  wire logic [15:0] py_step_in,      // Y post-modify
  input  wire logic        wb_en_in,        // Write-back enable
  input  wire logic [15:0] acc_wb_data_in,  // Write-back data
  output logic      [15:0] rd_data_out,     // Read data
  output logic      [31:0] prod_out,        // Product
  output logic      [15:0] mem_addr_out,    // Stack address
  output logic      [15:0] x_addr_out,      // X prefetch address
  output logic      [15:0] y_addr_out,      // Y prefetch address
  output logic      [15:0] stack_ptr_out,   // Current W15
  output logic      [15:0] frame_ptr_out,   // Current W14
  output logic             done_out         // Finished pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Multiplier with 17-bit operands; upper bit is sign or zero
  function automatic logic [31:0] mul17(input logic [15:0] a,
                                        input logic ua,
                                        input logic [15:0] b,
                                        input logic ub);
    logic signed [16:0] sa;
    logic signed [16:0] sb;
    logic signed [33:0] p;
    sa = $signed({~ua & a[15], a});
    sb = $signed({~ub & b[15], b});
    p  = sa * sb;
    return p[31:0];
  endfunction

  // Unsigned flag of a multiplicand picked from W4..W7
  function automatic logic mac_uns(input logic [1:0] us,
                                   input logic [1:0] sel);
    logic u;
    u = 1'b0;
    if (us == SIGN_UNSIGNED) begin
      u = 1'b1;
    end else if (us == SIGN_MIXED) begin
      u = ~sel[0];
    end
    return u;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wriu_state_t r;        // Registered state
  wriu_state_t n;        // Next state
  logic        go;       // Operation taken this cycle
  logic        is_mac;   // MAC group member
  logic [3:0]  xi;       // X multiplicand index
  logic [3:0]  yi;       // Y multiplicand index
  logic [3:0]  pxi;      // X pointer index
  logic [3:0]  pyi;      // Y pointer index
  logic [3:0]  ev;       // Even pair base

  assign go  = ce_in && op_valid_in;
  assign is_mac = (op_in inside {op_clr, op_dist, op_dist_acc, op_mac,
                   op_pstore, op_mpy, op_mpy_neg, op_msub});
  assign xi  = IDX_MAC_OP + {2'b00, x_op_sel_in};
  assign yi  = IDX_MAC_OP + {2'b00, y_op_sel_in};
  assign pxi = IDX_PTR_X + {3'b000, px_sel_in};
  assign pyi = IDX_PTR_Y + {3'b000, py_sel_in};
  assign ev  = {dst_in[3:1], 1'b0};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One operation per enabled cycle; all state holds while disabled
  always_comb begin
    n = r;
    if (ce_in) begin
      n.done = 1'b0;
    end
    if (go) begin
      n.done = 1'b1;
      unique case (op_in)
        op_nop: begin
          n.done = 1'b0;
        end
        // Word move from memory, any destination incl. W14/W15
        op_wr_word: begin
          n.w[dst_in] = file_data_in;
        end
        // Word move to memory, any source
        op_rd_word: begin
          n.rd = r.w[reg_a_in];
        end
        // Byte or word load into the default register
        op_ld_dflt: begin
          if (byte_in) begin
            n.w[IDX_DEFAULT][7:0] = file_data_in[7:0];
          end else begin
            n.w[IDX_DEFAULT] = file_data_in;
          end
        end
        // Byte or word store from the default register
        op_st_dflt: begin
          if (byte_in) begin
            n.rd = {8'h00, r.w[IDX_DEFAULT][7:0]};
          end else begin
            n.rd = r.w[IDX_DEFAULT];
          end
        end
        // Legacy unsigned multiply of memory by default register
        op_lmul: begin
          if (byte_in) begin
            n.w[IDX_PROD_LO] = {8'h00, r.w[IDX_DEFAULT][7:0]}
                             * {8'h00, file_data_in[7:0]};
          end else begin
            n.prod = mul17(r.w[IDX_DEFAULT], 1'b1, file_data_in, 1'b1);
            n.w[IDX_PROD_LO] = n.prod[15:0];
            n.w[IDX_PROD_HI] = n.prod[31:16];
          end
        end
        // General multiply into an even pair or the accumulator
        op_mul_pair: begin
          n.prod = mul17(r.w[reg_a_in], pair_unsigned_in[1],
                         r.w[reg_b_in], pair_unsigned_in[0]);
          if (!acc_dest_in) begin
            n.w[ev]        = n.prod[15:0];
            n.w[ev | 4'h1] = n.prod[31:16];
          end
        end
        // Accumulator class reads any register
        op_acc_read: begin
          n.rd = r.w[reg_a_in];
        end
        // MAC group: fixed operands, pointers, offset, write-back
        op_clr, op_dist, op_dist_acc, op_mac, op_pstore, op_mpy,
        op_mpy_neg, op_msub: begin
          if (op_in != op_clr && op_in != op_pstore) begin
            n.prod = mul17(r.w[xi], mac_uns(multiply_sign_select_in,
                           x_op_sel_in), r.w[yi],
                           mac_uns(multiply_sign_select_in,
                           y_op_sel_in));
          end
          if (px_en_in) begin
            if (px_off_in) begin
              n.xaddr = r.w[pxi] + r.w[IDX_OFFSET];
            end else begin
              n.xaddr = r.w[pxi];
              n.w[pxi] = r.w[pxi] + px_step_in;
            end
          end
          if (py_en_in) begin
            if (py_off_in) begin
              n.yaddr = r.w[pyi] + r.w[IDX_OFFSET];
            end else begin
              n.yaddr = r.w[pyi];
              n.w[pyi] = r.w[pyi] + py_step_in;
            end
          end
          if (wb_en_in) begin
            n.w[IDX_WB] = acc_wb_data_in;
          end
        end
        // Push a register; pointer grows by one word
        op_push: begin
          n.maddr = r.w[IDX_SP];
          n.rd    = r.w[reg_a_in];
          n.w[IDX_SP] = r.w[IDX_SP] + STACK_STEP;
        end
        // Pop into a register; pointer update wins on W15
        op_pop: begin
          n.maddr = r.w[IDX_SP] - STACK_STEP;
          n.w[dst_in] = file_data_in;
          n.w[IDX_SP] = r.w[IDX_SP] - STACK_STEP;
        end
        // Calls and traps stack a two-word return address
        op_call, op_relative_call_op, op_trap: begin
          n.maddr = r.w[IDX_SP];
          n.w[IDX_SP] = r.w[IDX_SP] + CALL_STEP;
        end
        // Returns unstack the return address
        op_ret, op_ret_int, op_ret_lit: begin
          n.maddr = r.w[IDX_SP] - CALL_STEP;
          n.w[IDX_SP] = r.w[IDX_SP] - CALL_STEP;
        end
        // Save frame pointer, open a frame of the literal size
        op_link: begin
          n.maddr = r.w[IDX_SP];
          n.rd    = r.w[IDX_FP];
          n.w[IDX_FP] = r.w[IDX_SP] + STACK_STEP;
          n.w[IDX_SP] = r.w[IDX_SP] + STACK_STEP + frame_lit_in;
        end
        // Drop the frame; saved frame pointer arrives on memory data
        op_unlink: begin
          n.maddr = r.w[IDX_FP] - STACK_STEP;
          n.w[IDX_SP] = r.w[IDX_FP] - STACK_STEP;
          n.w[IDX_FP] = file_data_in;
        end
        default: begin
          n.done = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset clears every register to a known value
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rd_data_out   = r.rd;
  assign prod_out      = r.prod;
  assign mem_addr_out  = r.maddr;
  assign x_addr_out    = r.xaddr;
  assign y_addr_out    = r.yaddr;
  assign stack_ptr_out = r.w[IDX_SP];
  assign frame_ptr_out = r.w[IDX_FP];
  assign done_out      = r.done;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_lmul_word;
    go && op_in == op_lmul && !byte_in;
  endsequence

  sequence s_lmul_byte;
    go && op_in == op_lmul && byte_in;
  endsequence

  // Any multiplying MAC member taken with the mixed sign selection
  sequence s_mixed_mac;
    go && is_mac && op_in != op_clr && op_in != op_pstore
      && multiply_sign_select_in == SIGN_MIXED;
  endsequence

  a_legacy_word_prod: assert property (s_lmul_word |=>
    {r.w[IDX_PROD_HI], r.w[IDX_PROD_LO]} ==
      32'($past(r.w[IDX_DEFAULT])) * 32'($past(file_data_in)))
    else $error("legacy word product not in W3:W2");

  a_legacy_byte_prod: assert property (s_lmul_byte |=>
    r.w[IDX_PROD_HI] == $past(r.w[IDX_PROD_HI]) &&
    r.w[IDX_PROD_LO] == 16'($past(r.w[IDX_DEFAULT][7:0]))
                        * 16'($past(file_data_in[7:0])))
    else $error("legacy byte product wrong or W3 changed");

  a_mixed_sign_mac: assert property (s_mixed_mac |=>
    r.done && r.prod == mul17($past(r.w[xi]), !$past(x_op_sel_in[0]),
                              $past(r.w[yi]), !$past(y_op_sel_in[0])))
    else $error("mixed sign product wrong");

  a_prefetch_offset: assert property (go && is_mac && px_en_in &&
    px_off_in |=> x_addr_out ==
      $past(r.w[IDX_PTR_X + {3'b000, px_sel_in}]) + $past(r.w[IDX_OFFSET]))
    else $error("offset prefetch address wrong");

  a_wb_dest_w13: assert property (go && is_mac && wb_en_in |=>
    r.w[IDX_WB] == $past(acc_wb_data_in) && done_out)
    else $error("write-back not in W13");

  a_push_sp_step: assert property (go && op_in == op_push |=>
    stack_ptr_out == $past(stack_ptr_out) + STACK_STEP &&
    mem_addr_out == $past(stack_ptr_out))
    else $error("push stack pointer step wrong");

  a_link_frame_ptr: assert property (go && op_in == op_link |=>
    frame_ptr_out == $past(stack_ptr_out) + STACK_STEP &&
    rd_data_out == $past(frame_ptr_out))
    else $error("link frame pointer wrong");

  a_byte_load_keep: assert property (go && op_in == op_ld_dflt &&
    byte_in |=> r.w[IDX_DEFAULT][15:8] == $past(r.w[IDX_DEFAULT][15:8]) &&
    r.w[IDX_DEFAULT][7:0] == $past(file_data_in[7:0]))
    else $error("byte load disturbed upper byte");

  a_word_move_any: assert property (go && op_in == op_wr_word |=>
    r.w[$past(dst_in)] == $past(file_data_in))
    else $error("word move destination wrong");

  a_pair_even_base: assert property (go && op_in == op_mul_pair &&
    !acc_dest_in |=> {r.w[{$past(dst_in[3:1]), 1'b1}],
                      r.w[{$past(dst_in[3:1]), 1'b0}]} == prod_out)
    else $error("pair product not at even base");

  a_freeze_state: assert property (!ce_in |=> $stable(r))
    else $error("state moved while clock enable low");

endmodule

// ==== tb/wriu_regfile_test.sv ====
/*
  Self-checking bench of the working register block: a model held in plain
  arrays follows every operation and is compared with the outputs.
  Assumes the package and the register block are compiled before it.
*/
`timescale 1ns/1ps
module wriu_regfile_test
  import wriu_pkg::*;
  ;
  // ------------------------------------------------------------
  // Stimulus, outputs and model state
  // ------------------------------------------------------------
  logic        clk_in, rst_in, ce_in, op_valid_in, byte_in, acc_dest_in;     // Control
  logic        px_en_in, px_sel_in, px_off_in, py_en_in, py_sel_in, py_off_in; // Prefetch
  logic        wb_en_in;                                                    // Write-back
  wriu_op_t    op_in;                                                       // Operation
  logic [3:0]  reg_a_in, reg_b_in, dst_in;                                  // Register indices
  logic [15:0] file_data_in, frame_lit_in, px_step_in, py_step_in, acc_wb_data_in;
  logic [1:0]  pair_unsigned_in, multiply_sign_select_in, x_op_sel_in, y_op_sel_in;
  logic [15:0] rd_data_out, mem_addr_out, x_addr_out, y_addr_out, stack_ptr_out, frame_ptr_out;
  logic [31:0] prod_out;                                                    // Product
  logic        done_out;                                                    // Finished pulse
  logic [15:0] m [16];                                                      // Model registers
  logic [15:0] v, xa, ya, ea, e2, sx, sy, wv;                               // Expectations
  logic [31:0] t, mp;                                                       // Model products
  logic [3:0]  ra, rb, rw, pf;                                              // Random picks
  logic [1:0]  xs, ys, ss;                                                  // Operand picks
  logic        ux, uy;                                                      // Operand signs
  wriu_op_t    op;                                                          // MAC operation
  int          seed, failures, check_count, cycles;                        // Bookkeeping

  wriu_regfile DUT (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .op_valid_in(op_valid_in), .op_in(op_in),
    .byte_in(byte_in), .reg_a_in(reg_a_in), .reg_b_in(reg_b_in), .dst_in(dst_in),
    .file_data_in(file_data_in), .frame_lit_in(frame_lit_in), .pair_unsigned_in(pair_unsigned_in),
    .acc_dest_in(acc_dest_in), .multiply_sign_select_in(multiply_sign_select_in),
    .x_op_sel_in(x_op_sel_in), .y_op_sel_in(y_op_sel_in), .px_en_in(px_en_in), .px_sel_in(px_sel_in),
    .px_off_in(px_off_in), .px_step_in(px_step_in), .py_en_in(py_en_in), .py_sel_in(py_sel_in),
    .py_off_in(py_off_in), .py_step_in(py_step_in), .wb_en_in(wb_en_in), .acc_wb_data_in(acc_wb_data_in),
    .rd_data_out(rd_data_out), .prod_out(prod_out), .mem_addr_out(mem_addr_out), .x_addr_out(x_addr_out),
    .y_addr_out(y_addr_out), .stack_ptr_out(stack_ptr_out), .frame_ptr_out(frame_ptr_out),
    .done_out(done_out)
  );

  // Free-running core clock, 100 ns period
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Cuts a hang short well past the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("ERROR timeout expected end seen hang");
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Compare, drive and report tasks
  // ------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_prod(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // 17 by 17 product, low 32 bits kept
  function automatic logic [31:0] mul17(logic [15:0] a, logic ua, logic [15:0] b, logic ub);
    logic signed [16:0] sa;
    logic signed [33:0] p;
    logic signed [16:0] sb;
    sa = {~ua & a[15], a};
    sb = {~ub & b[15], b};
    p = sa * sb;
    return p[31:0];
  endfunction

  // Presents one operation, waits for its pulse, checks both pointers
  task automatic go(input wriu_op_t o);
    op_in       <= o;
    op_valid_in <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      @(posedge clk_in);
      op_valid_in <= 1'b0;
      #1;
      if (done_out === 1'b1) break;
    end
    chk_flag("done", 1'b1, done_out);
    chk_word("sp", m[15], stack_ptr_out);
    chk_word("fp", m[14], frame_ptr_out);
  endtask

  task automatic rdw(input int i);
    @(posedge clk_in);
    reg_a_in <= 4'(i);
    go(op_rd_word);
    chk_word("rd", m[i], rd_data_out);
  endtask

  task automatic wrw(input int i, input logic [15:0] d);
    @(posedge clk_in);
    dst_in       <= 4'(i);
    file_data_in <= d;
    m[i] = d;
    go(op_wr_word);
  endtask

  // Default register load; byte mode replaces the low byte only
  task automatic ldf(input logic b, input logic [15:0] d);
    @(posedge clk_in);
    byte_in      <= b;
    file_data_in <= d;
    m[0] = b ? {m[0][15:8], d[7:0]} : d;
    go(op_ld_dflt);
  endtask

  task automatic stf(input logic b);
    @(posedge clk_in);
    byte_in <= b;
    go(op_st_dflt);
    chk_word("store", b ? {8'h00, m[0][7:0]} : m[0], rd_data_out);
  endtask

  // Legacy multiply of the default register by memory data
  task automatic lmul(input logic b, input logic [15:0] d);
    @(posedge clk_in);
    byte_in      <= b;
    file_data_in <= d;
    t = b ? 32'(m[0][7:0]) * 32'(d[7:0]) : 32'(m[0]) * 32'(d);
    if (!b) m[3] = t[31:16];
    m[2] = t[15:0];
    go(op_lmul);
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {ce_in, op_valid_in, byte_in, acc_dest_in, px_en_in, px_sel_in, px_off_in} = '0;
    {py_en_in, py_sel_in, py_off_in, wb_en_in, reg_a_in, reg_b_in, dst_in} = '0;
    {file_data_in, frame_lit_in, px_step_in, py_step_in, acc_wb_data_in} = '0;
    {pair_unsigned_in, multiply_sign_select_in, x_op_sel_in, y_op_sel_in} = '0;
    op_in = op_nop;
    rst_in = 1'b1;
    ce_in = 1'b1;
    seed = 48;
    mp = '0;
    for (int i = 0; i < 16; i++) m[i] = '0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 16; i++) rdw(i);
    $display("test reset done");
    for (int i = 0; i < 16; i++) wrw(i, 16'($random(seed)));
    for (int i = 0; i < 16; i++) rdw(i);
    $display("test word moves done");
    ldf(1'b0, 16'($random(seed)));
    rdw(0);
    ldf(1'b1, 16'($random(seed)));
    rdw(0);
    stf(1'b0);
    stf(1'b1);
    ldf(1'b0, 16'h7705);
    wrw(2, 16'h1235);
    wrw(3, 16'h1000);
    lmul(1'b1, 16'h1255);
    rdw(2);
    rdw(3);
    lmul(1'b0, 16'h1255);
    rdw(2);
    rdw(3);
    $display("test default register done");
    for (int k = 0; k < 8; k++) begin
      ra = 4'($random(seed));
      rb = 4'($random(seed));
      rw = 4'($random(seed));
      @(posedge clk_in);
      reg_a_in         <= ra;
      reg_b_in         <= rb;
      dst_in           <= rw;
      pair_unsigned_in <= 2'(k);
      acc_dest_in      <= k[2];
      t = mul17(m[ra], k[1], m[rb], k[0]);
      mp = t;
      if (!k[2]) m[{rw[3:1], 1'b1}] = t[31:16];
      if (!k[2]) m[{rw[3:1], 1'b0}] = t[15:0];
      go(op_mul_pair);
      chk_prod("pair", t, prod_out);
      rdw({rw[3:1], 1'b0});
      rdw({rw[3:1], 1'b1});
    end
    $display("test multiply pair done");
    for (int i = 0; i < 16; i++) begin
      op = wriu_op_t'(op_clr + i % 8);
      {xs, ys, ss} = {2'($random(seed)), 2'($random(seed)), 2'(i)};
      {pf, sx, sy, wv} = {4'($random(seed)), 16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
      @(posedge clk_in);
      {multiply_sign_select_in, x_op_sel_in, y_op_sel_in} <= {ss, xs, ys};
      {px_en_in, px_sel_in, px_off_in, px_step_in} <= {1'b1, pf[0], pf[1], sx};
      {py_en_in, py_sel_in, py_off_in, py_step_in} <= {1'b1, pf[2], pf[3], sy};
      {wb_en_in, acc_wb_data_in} <= {1'b1, wv};
      ux = ss == 2'h1 || (ss == 2'h2 && !xs[0]);
      uy = ss == 2'h1 || (ss == 2'h2 && !ys[0]);
      if (op != op_clr && op != op_pstore) mp = mul17(m[4+xs], ux, m[4+ys], uy);
      xa = pf[1] ? m[8+pf[0]] + m[12] : m[8+pf[0]];
      ya = pf[3] ? m[10+pf[2]] + m[12] : m[10+pf[2]];
      if (!pf[1]) m[8+pf[0]] += sx;
      if (!pf[3]) m[10+pf[2]] += sy;
      m[13] = wv;
      go(op);
      chk_prod("mac", mp, prod_out);
      chk_word("xaddr", xa, x_addr_out);
      chk_word("yaddr", ya, y_addr_out);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_in);
      reg_a_in <= 4'(i);
      go(op_acc_read);
      chk_word("acc", m[i], rd_data_out);
      chk_word("xhold", xa, x_addr_out);
    end
    for (int i = 8; i < 14; i++) rdw(i);
    $display("test mac group done");
    wrw(15, 16'h0800);
    wrw(14, 16'h0000);
    @(posedge clk_in);
    reg_a_in <= 4'h5;
    ea = m[15];
    m[15] += 16'h0002;
    go(op_push);
    chk_word("push", ea, mem_addr_out);
    chk_word("pdata", m[5], rd_data_out);
    v = 16'($random(seed));
    @(posedge clk_in);
    {dst_in, file_data_in} <= {4'h6, v};
    m[15] -= 16'h0002;
    m[6] = v;
    go(op_pop);
    chk_word("pop", m[15], mem_addr_out);
    rdw(6);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      ea = m[15];
      m[15] += 16'h0004;
      go(wriu_op_t'(op_call + i));
      chk_word("call", ea, mem_addr_out);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      m[15] -= 16'h0004;
      go(wriu_op_t'(op_ret + i));
      chk_word("ret", m[15], mem_addr_out);
    end
    @(posedge clk_in);
    frame_lit_in <= 16'h0010;
    {ea, e2} = {m[15], m[14]};
    m[14] = m[15] + 16'h0002;
    m[15] = m[15] + 16'h0012;
    go(op_link);
    chk_word("link", ea, mem_addr_out);
    chk_word("oldfp", e2, rd_data_out);
    v = 16'($random(seed));
    @(posedge clk_in);
    file_data_in <= v;
    m[15] = m[14] - 16'h0002;
    m[14] = v;
    go(op_unlink);
    chk_word("unlink", m[15], mem_addr_out);
    $display("test stack done");
    @(posedge clk_in);
    ce_in       <= 1'b0;
    op_in       <= op_push;
    op_valid_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk_flag("frozen", 1'b0, done_out);
    chk_word("spheld", m[15], stack_ptr_out);
    @(posedge clk_in);
    {ce_in, op_valid_in} <= 2'b10;
    $display("test clock enable done");
    close_out();
  end
endmodule
